// *** verilog/pdp_port_block.v ***
// Eight-bit bidirectional port D with port C pin 7 function mux
// Functional notes
// - Port D has 8 pins, each with a direction bit and a latch bit.
// - Each direction bit sets one pin only.
// - Any reset leaves all pins as inputs, drivers released.
// - Direction 0 drives latch out; direction 1 reads the pin level.
// - Pad configuration bit 7 set turns all port D pull-ups off.
// - A pin that is being driven never has its pull-up on.
// - Reset leaves all port D pull-ups disabled.
// - Control bit 4 makes port D an 8-bit parallel slave port.
// - In parallel slave mode pins carry data regardless of direction.
// - C7: compare unit output overrides with dir 0; capture with dir 1.
// - C7: serial sync data overrides with dir 1; async feeds receive.
// - C7 feeds CAN receive when remapped; direction must be 1.
// - Direction reads return stored value despite overrides.
`timescale 1ns/1ps
`include "pdp_defs_defs.vh"
module pdp_port_block #(
  parameter WIDTH = 8
) (
  input  wire             i_mclk,
  input  wire             i_reset_n,
  // APB slave
  input  wire             i_psel,
  input  wire             i_penable,
  input  wire             i_pwrite,
  input  wire [31:0]      i_paddr,
  input  wire [31:0]      i_pwdata,
  output wire [31:0]      o_prdata,
  output wire             o_pready,
  output wire             o_pslverr,
  // Port D pads
  input  wire [WIDTH-1:0] i_pd_pin,
  output wire [WIDTH-1:0] o_pd_out,
  output wire [WIDTH-1:0] o_pd_oe,
  output wire [WIDTH-1:0] o_pd_pullup,
  // Port C pads
  input  wire [WIDTH-1:0] i_pc_pin,
  output wire [WIDTH-1:0] o_pc_out,
  output wire [WIDTH-1:0] o_pc_oe,
  // Parallel slave data path
  input  wire             i_psp_drive,
  input  wire [WIDTH-1:0] i_psp_data,
  output wire [WIDTH-1:0] o_psp_data,
  output wire             o_psp_mode,
  // Port C pin 7 peripherals
  input  wire             i_cmp4_out,
  input  wire             i_serial1_sync_tx,
  input  wire             i_serial1_sync_data,
  output wire             o_cmp4_capture,
  output wire             o_serial1_receive,
  output wire             o_can_receive
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg  [WIDTH-1:0] d_latch_q;
  reg  [WIDTH-1:0] d_dir_q;
  reg  [7:0]       pad_cfg_q;
  reg  [7:0]       psp_ctrl_q;
  reg  [WIDTH-1:0] c_latch_q;
  reg  [WIDTH-1:0] c_dir_q;
  reg  [7:0]       od_sel_q;
  reg  [3:0]       periph_q;
  reg  [31:0]      prdata_q;
  reg              pready_q;
  reg              pslverr_q;
  reg  [WIDTH-1:0] pd_out_q;
  reg  [WIDTH-1:0] pd_oe_q;
  reg  [WIDTH-1:0] pd_pu_q;
  reg  [WIDTH-1:0] pc_out_q;
  reg  [WIDTH-1:0] pc_oe_q;
  reg  [WIDTH-1:0] psp_data_q;
  reg              psp_mode_q;
  reg              cmp4_cap_q;
  reg              ser1_rx_q;
  reg              can_rx_q;

  wire [WIDTH-1:0] d_level;
  wire [WIDTH-1:0] c_level;
  wire [WIDTH-1:0] d_out_d;
  wire [WIDTH-1:0] d_oe_d;
  wire [WIDTH-1:0] d_pu_d;
  wire [WIDTH-1:0] c_out_d;
  wire [WIDTH-1:0] c_oe_d;
  wire [WIDTH-1:0] c_ovr_en;
  wire [WIDTH-1:0] c_ovr_data;
  wire [WIDTH-1:0] c_od;
  wire [WIDTH-1:0] d_mode_rep;
  wire [WIDTH-1:0] d_drv_rep;

  // ----------------------------------------------------------------
  // Pin input synchronisers
  // ----------------------------------------------------------------
  pdp_pin_sync #(.WIDTH(WIDTH)) u_sync_d (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_async   (i_pd_pin),
    .o_level   (d_level)
  );

  pdp_pin_sync #(.WIDTH(WIDTH)) u_sync_c (
    .i_mclk    (i_mclk),
    .i_reset_n (i_reset_n),
    .i_async   (i_pc_pin),
    .o_level   (c_level)
  );

  // ----------------------------------------------------------------
  // Port D output selection
  // ----------------------------------------------------------------
  wire psp_on  = psp_ctrl_q[`PDP_BIT_PSP_MODE];
  assign d_mode_rep = {WIDTH{psp_on}};
  assign d_drv_rep  = {WIDTH{i_psp_drive}};

  // Slave mode owns every pin; the direction bits are bypassed
  pdp_pad_mux #(.WIDTH(WIDTH)) u_mux_d (
    .i_dir        (d_dir_q),
    .i_latch      (d_latch_q),
    .i_ovr_en     (d_mode_rep),
    .i_ovr_data   (i_psp_data),
    .i_ovr_drive  (d_drv_rep),
    .i_open_drain ({WIDTH{1'b0}}),
    .i_pullup_off (pad_cfg_q[`PDP_BIT_PULLUP_CTRL]),
    .o_data       (d_out_d),
    .o_oe         (d_oe_d),
    .o_pullup     (d_pu_d)
  );

  // ----------------------------------------------------------------
  // Port C pin 7 function selection
  // ----------------------------------------------------------------
  wire c7_dir     = c_dir_q[`PDP_BIT_PIN7];
  wire ser1_on    = periph_q[`PDP_BIT_SER1_EN];
  wire ser1_sync  = periph_q[`PDP_BIT_SER1_SYNC];
  wire cmp4_on    = periph_q[`PDP_BIT_CMP4_EN];
  // Serial sync data needs direction 1, compare output direction 0
  wire ser1_drv   = ser1_on & ser1_sync & c7_dir & i_serial1_sync_tx;
  wire cmp4_drv   = cmp4_on & ~c7_dir;
  wire c7_ovr     = ser1_drv | cmp4_drv;
  wire c7_data    = ser1_drv ? i_serial1_sync_data : i_cmp4_out;
  wire c7_od      = ser1_drv ? od_sel_q[`PDP_BIT_OD_SER1]
                             : od_sel_q[`PDP_BIT_OD_CMP4];

  assign c_ovr_en   = {c7_ovr,  {(WIDTH-1){1'b0}}};
  assign c_ovr_data = {c7_data, {(WIDTH-1){1'b0}}};
  assign c_od       = {c7_od,   {(WIDTH-1){1'b0}}};

  pdp_pad_mux #(.WIDTH(WIDTH)) u_mux_c (
    .i_dir        (c_dir_q),
    .i_latch      (c_latch_q),
    .i_ovr_en     (c_ovr_en),
    .i_ovr_data   (c_ovr_data),
    .i_ovr_drive  (c_ovr_en),
    .i_open_drain (c_od),
    .i_pullup_off (1'b1),
    .o_data       (c_out_d),
    .o_oe         (c_oe_d),
    .o_pullup     ()
  );

  // ----------------------------------------------------------------
  // Registered pad and peripheral outputs
  // ----------------------------------------------------------------
  // One cycle of latency buys glitch-free pads
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pd_out_q   <= `PDP_RST_ZERO8;
      pd_oe_q    <= `PDP_RST_ZERO8;
      pd_pu_q    <= `PDP_RST_ZERO8;
      pc_out_q   <= `PDP_RST_ZERO8;
      pc_oe_q    <= `PDP_RST_ZERO8;
      psp_data_q <= `PDP_RST_ZERO8;
      psp_mode_q <= 1'b0;
      cmp4_cap_q <= 1'b0;
      ser1_rx_q  <= 1'b1;
      can_rx_q   <= 1'b1;
    end else begin
      pd_out_q   <= d_out_d;
      pd_oe_q    <= d_oe_d;
      pd_pu_q    <= d_pu_d;
      pc_out_q   <= c_out_d;
      pc_oe_q    <= c_oe_d;
      psp_data_q <= d_level;
      psp_mode_q <= psp_on;
      // Receive inputs idle high, capture idles low, when the pin is not given to the unit
      cmp4_cap_q <= cmp4_on & c7_dir & c_level[`PDP_BIT_PIN7];
      ser1_rx_q  <= ~(ser1_on & ~ser1_sync & c7_dir)
                    | c_level[`PDP_BIT_PIN7];
      can_rx_q   <= ~(periph_q[`PDP_BIT_CAN_REMAP] & c7_dir)
                    | c_level[`PDP_BIT_PIN7];
    end
  end

  // ----------------------------------------------------------------
  // APB slave: one wait state, then pready for one cycle
  // ----------------------------------------------------------------
  wire [7:0] addr   = i_paddr[`PDP_ADDR_W-1:0];
  wire       hi_hit = (i_paddr[31:`PDP_ADDR_W] == 24'h00_0000);
  wire       acc    = i_psel & i_penable & ~pready_q;
  wire       wr_go  = i_psel & i_penable & pready_q & i_pwrite;
  reg  [31:0] rd_d;
  reg         err_d;

  // Read mux and address check
  always @* begin
    rd_d  = `PDP_RDATA_ZERO;
    err_d = 1'b0;
    if (!hi_hit) begin
      err_d = 1'b1;
    end else if (addr == `PDP_OFS_D_LEVELS) begin
      rd_d[7:0] = d_level;
    end else if (addr == `PDP_OFS_D_LATCH) begin
      rd_d[7:0] = d_latch_q;
    end else if (addr == `PDP_OFS_D_DIR) begin
      rd_d[7:0] = d_dir_q;
    end else if (addr == `PDP_OFS_PAD_CFG) begin
      rd_d[7:0] = pad_cfg_q;
    end else if (addr == `PDP_OFS_PSP_CTRL) begin
      rd_d[7:0] = psp_ctrl_q;
    end else if (addr == `PDP_OFS_C_LEVELS) begin
      rd_d[7:0] = c_level;
    end else if (addr == `PDP_OFS_C_LATCH) begin
      rd_d[7:0] = c_latch_q;
    end else if (addr == `PDP_OFS_C_DIR) begin
      rd_d[7:0] = c_dir_q;
    end else if (addr == `PDP_OFS_OD_SEL) begin
      rd_d[7:0] = od_sel_q;
    end else if (addr == `PDP_OFS_PERIPH_CFG) begin
      rd_d[3:0] = periph_q;
    end else begin
      err_d = 1'b1;
    end
  end

  // Handshake and read data
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= `PDP_RDATA_ZERO;
    end else begin
      pready_q  <= acc;
      pslverr_q <= acc & err_d;
      if (acc && !i_pwrite) begin
        prdata_q <= rd_d;
      end
    end
  end

  // Register writes take effect at the completing edge
  always @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      d_latch_q  <= `PDP_RST_LATCH;
      d_dir_q    <= `PDP_RST_DIR;
      pad_cfg_q  <= `PDP_RST_PAD_CFG;
      psp_ctrl_q <= `PDP_RST_ZERO8;
      c_latch_q  <= `PDP_RST_LATCH;
      c_dir_q    <= `PDP_RST_DIR;
      od_sel_q   <= `PDP_RST_ZERO8;
      periph_q   <= `PDP_RST_PERIPH;
    end else if (wr_go && hi_hit) begin
      if (addr == `PDP_OFS_D_LEVELS || addr == `PDP_OFS_D_LATCH) begin
        d_latch_q <= i_pwdata[7:0];
      end else if (addr == `PDP_OFS_D_DIR) begin
        d_dir_q <= i_pwdata[7:0];
      end else if (addr == `PDP_OFS_PAD_CFG) begin
        pad_cfg_q <= i_pwdata[7:0];
      end else if (addr == `PDP_OFS_PSP_CTRL) begin
        psp_ctrl_q <= i_pwdata[7:0];
      end else if (addr == `PDP_OFS_C_LEVELS ||
                   addr == `PDP_OFS_C_LATCH) begin
        c_latch_q <= i_pwdata[7:0];
      end else if (addr == `PDP_OFS_C_DIR) begin
        c_dir_q <= i_pwdata[7:0];
      end else if (addr == `PDP_OFS_OD_SEL) begin
        od_sel_q <= i_pwdata[7:0];
      end else if (addr == `PDP_OFS_PERIPH_CFG) begin
        periph_q <= i_pwdata[3:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Output wiring
  // ----------------------------------------------------------------
  assign o_prdata          = prdata_q;
  assign o_pready          = pready_q;
  assign o_pslverr         = pslverr_q;
  assign o_pd_out          = pd_out_q;
  assign o_pd_oe           = pd_oe_q;
  assign o_pd_pullup       = pd_pu_q;
  assign o_pc_out          = pc_out_q;
  assign o_pc_oe           = pc_oe_q;
  assign o_psp_data        = psp_data_q;
  assign o_psp_mode        = psp_mode_q;
  assign o_cmp4_capture    = cmp4_cap_q;
  assign o_serial1_receive = ser1_rx_q;
  assign o_can_receive     = can_rx_q;

endmodule

// *** include/pdp_defs_defs.vh ***
// Register map, field positions and reset values of the port block
`ifndef PDP_DEFS_DEFS_VH
`define PDP_DEFS_DEFS_VH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define PDP_ADDR_W          8
`define PDP_OFS_D_LEVELS    8'h00
`define PDP_OFS_D_LATCH     8'h04
`define PDP_OFS_D_DIR       8'h08
`define PDP_OFS_PAD_CFG     8'h0C
`define PDP_OFS_PSP_CTRL    8'h10
`define PDP_OFS_C_LEVELS    8'h14
`define PDP_OFS_C_LATCH     8'h18
`define PDP_OFS_C_DIR       8'h1C
`define PDP_OFS_OD_SEL      8'h20
`define PDP_OFS_PERIPH_CFG  8'h24

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define PDP_BIT_PULLUP_CTRL 7
`define PDP_BIT_PSP_MODE    4
`define PDP_BIT_OD_CMP4     5
`define PDP_BIT_OD_SER1     0
`define PDP_BIT_CAN_REMAP   0
`define PDP_BIT_CMP4_EN     1
`define PDP_BIT_SER1_EN     2
`define PDP_BIT_SER1_SYNC   3
`define PDP_BIT_PIN7        7

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define PDP_RST_DIR         8'hFF
`define PDP_RST_LATCH       8'h00
`define PDP_RST_PAD_CFG     8'h80
`define PDP_RST_ZERO8       8'h00
`define PDP_RST_PERIPH      4'h0
`define PDP_RDATA_ZERO      32'h0000_0000

`endif

// *** verilog/pdp_pin_sync.v ***
// Three-stage pin synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
module pdp_pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             i_mclk,
  input  wire             i_reset_n,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_level
);

  // ----------------------------------------------------------------
  // Per-bit chain
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
      reg s1_q;
      reg s2_q;
      reg s3_q;
      reg lvl_q;
      // Stage one is read only by stage two; a change counts once
      // stages two and three agree, which masks a late settle
      always @(posedge i_mclk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          s1_q  <= 1'b0;
          s2_q  <= 1'b0;
          s3_q  <= 1'b0;
          lvl_q <= 1'b0;
        end else begin
          s1_q <= i_async[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
          if (s2_q == s3_q) begin
            lvl_q <= s3_q;
          end
        end
      end
      assign o_level[g] = lvl_q;
    end
  endgenerate

endmodule

// *** verilog/pdp_pad_mux.v ***
// Per-pin output selection: override, latch, enable and pull-up
`timescale 1ns/1ps
module pdp_pad_mux #(
  parameter WIDTH = 8
) (
  input  wire [WIDTH-1:0] i_dir,
  input  wire [WIDTH-1:0] i_latch,
  input  wire [WIDTH-1:0] i_ovr_en,
  input  wire [WIDTH-1:0] i_ovr_data,
  input  wire [WIDTH-1:0] i_ovr_drive,
  input  wire [WIDTH-1:0] i_open_drain,
  input  wire             i_pullup_off,
  output wire [WIDTH-1:0] o_data,
  output wire [WIDTH-1:0] o_oe,
  output wire [WIDTH-1:0] o_pullup
);

  // ----------------------------------------------------------------
  // Pin cells
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      wire drv_on;
      wire dat;
      // Override takes the pin whatever the direction bit says
      assign drv_on = i_ovr_en[g] ? i_ovr_drive[g] : ~i_dir[g];
      assign dat    = i_ovr_en[g] ? i_ovr_data[g]  : i_latch[g];
      assign o_data[g] = dat;
      // Open drain only pulls low; a high is left to the board
      assign o_oe[g] = drv_on & ~(i_open_drain[g] & dat);
      // No pull-up while the pin is driven
      assign o_pullup[g] = ~i_pullup_off & ~drv_on;
    end
  endgenerate

endmodule

// *** test/pdp_pin_model.sv ***
// External circuit model for one 8-pin pad group
`timescale 1ns/1ps
module pdp_pin_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_out,
  input  wire logic [7:0] i_oe,
  input  wire logic [7:0] i_pull,
  input  wire logic [7:0] i_ext,
  input  wire logic [7:0] i_ext_en,
  output wire logic [7:0] o_pin
);
  logic [7:0] float_q;

  // Undriven pins wander each cycle, so a floating read never looks stable
  always @(posedge i_mclk) begin
    float_q <= (float_q === 8'hFF) ? 8'h00 : 8'hFF;
  end

  // Device drive wins, then the outside driver, then the pull-up level
  assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
               | (~i_oe & ~i_ext_en & i_pull)
               | (~i_oe & ~i_ext_en & ~i_pull & float_q);
endmodule

// *** test/pdp_port_checker.sv ***
// Concurrent checks on the bus and port D pads of the port block
`timescale 1ns/1ps
module pdp_port_checker #(
  parameter WIDTH = 8
) (
  input wire logic             i_mclk,
  input wire logic             i_reset_n,
  input wire logic             i_psel,
  input wire logic             i_penable,
  input wire logic [31:0]      o_prdata,
  input wire logic             o_pready,
  input wire logic             o_pslverr,
  input wire logic [WIDTH-1:0] o_pd_out,
  input wire logic [WIDTH-1:0] o_pd_oe,
  input wire logic [WIDTH-1:0] o_pd_pullup,
  input wire logic             i_psp_drive,
  input wire logic [WIDTH-1:0] i_psp_data,
  input wire logic             o_psp_mode
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);

  AST_PU_OFF_ON_OUT: assert property (!(|(o_pd_pullup & o_pd_oe)))
    else $error("pull-up on a driven pin");
  AST_RESET_STATE: assert property ($rose(i_reset_n) |->
    o_pd_oe == 0 && o_pd_pullup == 0) else $error("pads not reset");
  AST_READY_NEXT: assert property (i_psel && i_penable && !o_pready
    |=> o_pready) else $error("ready late");
  AST_READY_PULSE: assert property (o_pready |=> !o_pready)
    else $error("ready held");
  AST_ERR_WITH_READY: assert property (o_pslverr |-> o_pready)
    else $error("error without ready");
  AST_ERR_DATA_ZERO: assert property (o_pslverr |-> o_prdata == 0)
    else $error("refused read gave data");
  AST_UPPER_ZERO: assert property (o_pready |-> o_prdata[31:8] == 0)
    else $error("upper read bits set");
  AST_PSP_DRIVE: assert property (o_psp_mode && $past(o_psp_mode)
    && i_psp_drive && $past(i_psp_drive) && $stable(i_psp_data)
    |-> &o_pd_oe && o_pd_out == i_psp_data) else $error("parallel drive");
  AST_PSP_RELEASE: assert property (o_psp_mode && $past(o_psp_mode)
    && !i_psp_drive && !$past(i_psp_drive) |-> o_pd_oe == 0)
    else $error("parallel release");
endmodule

bind pdp_port_block pdp_port_checker #(.WIDTH(WIDTH)) pdp_port_checker_inst (
  .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_psel(i_psel),
  .i_penable(i_penable), .o_prdata(o_prdata), .o_pready(o_pready),
  .o_pslverr(o_pslverr), .o_pd_out(o_pd_out), .o_pd_oe(o_pd_oe),
  .o_pd_pullup(o_pd_pullup), .i_psp_drive(i_psp_drive),
  .i_psp_data(i_psp_data), .o_psp_mode(o_psp_mode));

// *** test/test_bidirectional_port_d_pin_mux.sv ***
// Self-checking bench for port D and the port C pin 7 mux
`timescale 1ns/1ps
`include "pdp_defs_defs.vh"
module test_bidirectional_port_d_pin_mux;
  logic        i_mclk, i_reset_n, i_psel, i_penable, i_pwrite, err;
  logic [31:0] i_paddr, i_pwdata, o_prdata, rd;
  logic        o_pready, o_pslverr, i_psp_drive, o_psp_mode, i_cmp4_out;
  logic [7:0]  i_pd_pin, o_pd_out, o_pd_oe, o_pd_pullup, i_pc_pin;
  logic [7:0]  o_pc_out, o_pc_oe, i_psp_data, o_psp_data;
  logic [7:0]  d_ext, d_en, c_ext, c_en;
  logic        i_serial1_sync_tx, i_serial1_sync_data, o_cmp4_capture;
  logic        o_serial1_receive, o_can_receive;
  int          num_errors, cmp_count, cyc;

  pdp_port_block pdp_port_block_inst (.i_mclk(i_mclk),
    .i_reset_n(i_reset_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
    .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_pd_pin(i_pd_pin), .o_pd_out(o_pd_out), .o_pd_oe(o_pd_oe),
    .o_pd_pullup(o_pd_pullup), .i_pc_pin(i_pc_pin), .o_pc_out(o_pc_out),
    .o_pc_oe(o_pc_oe), .i_psp_drive(i_psp_drive), .i_psp_data(i_psp_data),
    .o_psp_data(o_psp_data), .o_psp_mode(o_psp_mode),
    .i_cmp4_out(i_cmp4_out), .i_serial1_sync_tx(i_serial1_sync_tx),
    .i_serial1_sync_data(i_serial1_sync_data),
    .o_cmp4_capture(o_cmp4_capture), .o_serial1_receive(o_serial1_receive),
    .o_can_receive(o_can_receive));
  pdp_pin_model pd_pins_inst (.i_mclk(i_mclk), .i_out(o_pd_out),
    .i_oe(o_pd_oe), .i_pull(o_pd_pullup), .i_ext(d_ext), .i_ext_en(d_en),
    .o_pin(i_pd_pin));
  pdp_pin_model pc_pins_inst (.i_mclk(i_mclk), .i_out(o_pc_out),
    .i_oe(o_pc_oe), .i_pull(8'h00), .i_ext(c_ext), .i_ext_en(c_en),
    .o_pin(i_pc_pin));

  // Free-running core clock
  initial begin
    i_mclk = 0;
    forever #4 i_mclk = ~i_mclk;
  end

  // Cut a hang short
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      report_and_stop;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task wt(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // One APB transfer; request held until ready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    i_psel <= 1;
    i_penable <= 0;
    i_pwrite <= w;
    i_paddr <= {24'h00_0000, a};
    i_pwdata <= d;
    @(posedge i_mclk);
    i_penable <= 1;
    do @(posedge i_mclk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 0;
    i_penable <= 0;
    @(posedge i_mclk);
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      $display("unexpected at %0t got %h expected %h", $time, g, e);
      num_errors++;
    end
  endtask

  task report_and_stop;
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset;
    chk(o_pd_oe, 8'h00);
    chk(o_pd_pullup, 8'h00);
    apb(0, `PDP_OFS_D_DIR, 0);
    chk(rd, 32'h0000_00FF);
    apb(0, `PDP_OFS_PAD_CFG, 0);
    chk(rd, 32'h0000_0080);
    apb(0, 8'h40, 0);
    chk({rd[30:0], err}, 32'h0000_0001);
    $display("reset test done");
  endtask

  // Latch written through the level register, then per-pin direction
  task t_dir;
    apb(1, `PDP_OFS_D_LEVELS, 32'h0000_00A5);
    apb(0, `PDP_OFS_D_LATCH, 0);
    chk(rd, 32'h0000_00A5);
    apb(1, `PDP_OFS_D_DIR, 32'h0000_00CF);
    wt(1);
    chk(o_pd_oe, 8'h30);
    chk(o_pd_out & o_pd_oe, 8'h20);
    apb(1, `PDP_OFS_D_DIR, 32'h0000_00CE);
    d_ext <= 8'h96;
    d_en <= 8'hFF;
    wt(6);
    chk(o_pd_oe, 8'h31);
    apb(0, `PDP_OFS_D_LEVELS, 0);
    chk(rd, 32'h0000_00A7);
    $display("direction test done");
  endtask

  task t_pullup;
    d_en <= 8'h00;
    apb(1, `PDP_OFS_PAD_CFG, 0);
    wt(6);
    chk(o_pd_pullup, 8'hCE);
    apb(0, `PDP_OFS_D_LEVELS, 0);
    chk(rd, 32'h0000_00EF);
    apb(1, `PDP_OFS_PAD_CFG, 32'h0000_0080);
    wt(1);
    chk(o_pd_pullup, 8'h00);
    $display("pull-up test done");
  endtask

  task t_psp;
    i_psp_drive <= 1;
    i_psp_data <= 8'h5A;
    apb(1, `PDP_OFS_PSP_CTRL, 32'h0000_0010);
    wt(2);
    chk(o_psp_mode, 1);
    chk(o_pd_oe, 8'hFF);
    chk(o_pd_out, 8'h5A);
    i_psp_drive <= 0;
    d_ext <= 8'h3C;
    d_en <= 8'hFF;
    wt(7);
    chk(o_pd_oe, 8'h00);
    chk(o_psp_data, 8'h3C);
    apb(1, `PDP_OFS_PSP_CTRL, 0);
    wt(1);
    chk(o_pd_oe, 8'h31);
    $display("parallel test done");
  endtask

  // Pin C7 owners: compare, capture, sync serial, receive, CAN remap
  task t_c7;
    apb(1, `PDP_OFS_C_DIR, 32'h0000_007F);
    apb(1, `PDP_OFS_PERIPH_CFG, 32'h0000_0002);
    i_cmp4_out <= 1;
    wt(2);
    chk({o_pc_oe[7], o_pc_out[7]}, 2'b11);
    // Open drain on the compare output: a high releases the pin
    apb(1, `PDP_OFS_OD_SEL, 32'h0000_0020);
    wt(1);
    chk(o_pc_oe[7], 0);
    i_cmp4_out <= 0;
    c_ext <= 8'h80;
    c_en <= 8'h80;
    apb(1, `PDP_OFS_C_DIR, 32'h0000_00FF);
    wt(6);
    chk(o_cmp4_capture, 1);
    apb(1, `PDP_OFS_PERIPH_CFG, 32'h0000_000C);
    i_serial1_sync_tx <= 1;
    i_serial1_sync_data <= 1;
    wt(2);
    chk({o_pc_oe[7], o_pc_out[7]}, 2'b11);
    apb(0, `PDP_OFS_C_DIR, 0);
    chk(rd, 32'h0000_00FF);
    i_serial1_sync_tx <= 0;
    c_ext <= 8'h00;
    apb(1, `PDP_OFS_PERIPH_CFG, 32'h0000_0004);
    wt(6);
    chk({o_pc_oe[7], o_serial1_receive}, 2'b00);
    apb(1, `PDP_OFS_PERIPH_CFG, 32'h0000_0001);
    wt(2);
    chk(o_can_receive, 0);
    $display("pin 7 test done");
  endtask

  // Main sequence
  initial begin
    {i_psel, i_penable, i_pwrite, i_psp_drive, i_cmp4_out} = 0;
    {i_serial1_sync_tx, i_serial1_sync_data} = 0;
    {i_paddr, i_pwdata, i_psp_data} = 0;
    {d_ext, d_en, c_ext, c_en} = 0;
    {num_errors, cmp_count, cyc} = 0;
    i_reset_n = 0;
    wt(6);
    i_reset_n <= 1;
    wt(1);
    t_reset;
    t_dir;
    t_pullup;
    t_psp;
    t_c7;
    report_and_stop;
  end
endmodule
